/* logic/dac_port_pkg.sv */
// Functional notes
// - Every frame carries one 16-bit word: two control bits then data bits.
// - Narrower variants keep the upper 12, 10 or 8 data bits only.
// - After reset, serial data is sampled on falling shift clock edges.
// - A frame that changes the clock edge leaves the converter output untouched.
// - Reset restores falling-edge sampling and zero scale in register and output.
// - Code 00 loads and updates the converter; codes 01 and 10 are reserved.
// - Code 11 makes later frames sample on the rising shift clock edge.
// - Active-low frame select is edge-triggered frame sync and chip enable.
// - Bits are taken only while frame select is low.
// - The serial port powers up on the falling edge of frame select.
// - The rising edge of frame select powers down clock and data inputs.
// - Frame select rising after sixteen edges transfers the word to the converter; here it is queued and dropped with overflow when the queue is full.
// - Words are shifted most significant bit first.
// - While selected, old shift contents leave on serial output at rising edges.
package dac_port_pkg;
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 14;
  localparam int CTRL_HI = 15;
  localparam int CTRL_LO = 14;
  localparam int DATA_MSB = 13;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] FULL_COUNT = 5'h10;
  localparam logic [1:0] CODE_LOAD = 2'h0;
  localparam logic [1:0] CODE_RISE = 2'h3;
  localparam logic [DATA_BITS-1:0] ZERO_SCALE = 14'h0000;
  localparam logic [DATA_BITS-1:0] MASK_14 = 14'h3FFF;
  localparam logic [DATA_BITS-1:0] MASK_12 = 14'h3FFC;
  localparam logic [DATA_BITS-1:0] MASK_10 = 14'h3FF0;
  localparam logic [DATA_BITS-1:0] MASK_8 = 14'h3FC0;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    RES_14,
    RES_12,
    RES_10,
    RES_8
  } resolution_t;
endpackage

/* logic/word_fifo.sv */
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // word_fifo

/* logic/dac_serial_write_port.sv */
`timescale 1ns/10ps
module dac_serial_write_port (
  input wire logic clk_sys,
  input wire logic reset,
  input wire dac_port_pkg::resolution_t resolution,
  input wire logic frame_select_n,
  input wire logic shift_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic port_powered,
  output logic rising_edge_mode,
  output logic [dac_port_pkg::DATA_BITS-1:0] current_output,
  output logic output_update,
  input wire logic sink_ready,
  output logic overflow
);
  import dac_port_pkg::*;

  logic [2:0] sel_sync;
  logic [2:0] clk_sync;
  logic [1:0] din_sync;
  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic sample_edge;
  logic [WORD_BITS-1:0] shift_reg;
  logic [WORD_BITS-1:0] readback;
  logic [CNT_BITS-1:0] bit_count;
  logic fifo_valid;
  logic fifo_ready;
  logic [WORD_BITS-1:0] fifo_word;
  logic [DATA_BITS-1:0] dac_register;
  logic [DATA_BITS-1:0] data_mask;
  logic load_req;

  // Pins cross into clk_sys through two flops; the third flop feeds edge detection.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sel_sync <= 3'h7;
      clk_sync <= 3'h0;
      din_sync <= 2'h0;
    end else begin
      sel_sync <= {sel_sync[1:0], frame_select_n};
      clk_sync <= {clk_sync[1:0], shift_clock};
      din_sync <= {din_sync[0], serial_data_in};
    end
  end

  assign sel_fall = sel_sync[2] && !sel_sync[1];
  assign sel_rise = !sel_sync[2] && sel_sync[1];
  assign sck_rise = !clk_sync[2] && clk_sync[1];
  assign sck_fall = clk_sync[2] && !clk_sync[1];
  assign sample_edge = rising_edge_mode ? sck_rise : sck_fall;

  // The input stage is live only between the select edges.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_powered <= 1'b0;
    end else if (sel_fall) begin
      port_powered <= 1'b1;
    end else if (sel_rise) begin
      port_powered <= 1'b0;
    end
  end

  // Bits enter at the bottom so the first bit ends at the top.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shift_reg <= SHIFT_RESET;
      bit_count <= '0;
    end else if (sel_fall) begin
      bit_count <= '0;
    end else if (port_powered && !sel_sync[1] && sample_edge) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], din_sync[1]};
      if (bit_count != FULL_COUNT) begin
        bit_count <= bit_count + 1'b1;
      end
    end
  end

  // Readback presents the previous word, one bit per rising shift clock.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      readback <= SHIFT_RESET;
      serial_data_out <= 1'b0;
    end else if (sel_fall) begin
      readback <= shift_reg;
      serial_data_out <= 1'b0;
    end else if (port_powered && !sel_sync[1] && sck_rise) begin
      serial_data_out <= readback[WORD_BITS-1];
      readback <= {readback[WORD_BITS-2:0], 1'b0};
    end
  end

  assign load_req = sel_rise && port_powered && bit_count == FULL_COUNT;

  // A load word is queued; an edge change acts at once and never touches the output.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rising_edge_mode <= 1'b0;
    end else if (load_req && shift_reg[CTRL_HI:CTRL_LO] == CODE_RISE) begin
      rising_edge_mode <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      overflow <= 1'b0;
    end else begin
      overflow <= load_req && shift_reg[CTRL_HI:CTRL_LO] == CODE_LOAD && !fifo_ready;
    end
  end

  word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) load_queue (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(load_req && shift_reg[CTRL_HI:CTRL_LO] == CODE_LOAD),
    .in_ready(fifo_ready),
    .in_data(shift_reg),
    .out_valid(fifo_valid),
    .out_ready(sink_ready),
    .out_data(fifo_word)
  );

  always_comb begin
    unique case (resolution)
      RES_14: data_mask = MASK_14;
      RES_12: data_mask = MASK_12;
      RES_10: data_mask = MASK_10;
      RES_8: data_mask = MASK_8;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dac_register <= ZERO_SCALE;
      output_update <= 1'b0;
    end else begin
      output_update <= fifo_valid && sink_ready;
      if (fifo_valid && sink_ready) begin
        dac_register <= fifo_word[DATA_MSB:0] & data_mask;
      end
    end
  end

  assign current_output = dac_register;

  short_frame_a: assert property (@(posedge clk_sys) disable iff (reset)
    sel_rise && bit_count != FULL_COUNT |=> $stable(rising_edge_mode))
    else $error("short frame changed edge mode");
  edge_frame_a: assert property (@(posedge clk_sys) disable iff (reset)
    load_req && shift_reg[CTRL_HI:CTRL_LO] == CODE_RISE && !fifo_valid
    |=> (!output_update) [*3])
    else $error("edge frame updated output");
  rise_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
    load_req && shift_reg[CTRL_HI:CTRL_LO] == CODE_RISE |=> rising_edge_mode)
    else $error("edge mode not set");
  idle_shift_a: assert property (@(posedge clk_sys) disable iff (reset)
    sel_sync[1] && !sel_fall |=> $stable(bit_count) || bit_count == '0)
    else $error("bit counted while deselected");
  power_down_a: assert property (@(posedge clk_sys) disable iff (reset)
    sel_rise |=> !port_powered)
    else $error("port stayed powered");
  power_up_a: assert property (@(posedge clk_sys) disable iff (reset)
    sel_fall |=> port_powered ##0 bit_count == '0)
    else $error("port not powered");
  mask_width_a: assert property (@(posedge clk_sys) disable iff (reset)
    output_update |-> (current_output & ~data_mask) == '0)
    else $error("ignored bits reached output");
  reserved_code_a: assert property (@(posedge clk_sys) disable iff (reset)
    load_req && shift_reg[CTRL_HI] != shift_reg[CTRL_LO] && !fifo_valid
    |=> $stable(rising_edge_mode)
    ##1 !output_update)
    else $error("reserved code acted");
  // Reset must leave zero scale, falling-edge sampling and an idle port behind.
  reset_default_a: assert property (@(posedge clk_sys)
    $fell(reset) |-> current_output == ZERO_SCALE && !rising_edge_mode && !port_powered)
    else $error("reset state wrong");
  queue_source_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(fifo_valid) |-> $past(load_req))
    else $error("word queued without frame");
  mode_sticky_a: assert property (@(posedge clk_sys) disable iff (reset)
    rising_edge_mode |=> rising_edge_mode)
    else $error("edge mode dropped");
  readback_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    sel_sync[1] |=> $stable(serial_data_out))
    else $error("readback moved while deselected");
  shift_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    sel_sync[1] |=> $stable(shift_reg))
    else $error("shift register moved while deselected");
  count_limit_a: assert property (@(posedge clk_sys) disable iff (reset)
    bit_count <= FULL_COUNT)
    else $error("bit count past word length");
  overflow_cov: cover property (@(posedge clk_sys) disable iff (reset) overflow);
  reserved_cov: cover property (@(posedge clk_sys) disable iff (reset)
    load_req && shift_reg[CTRL_HI] != shift_reg[CTRL_LO]);
  load_cov: cover property (@(posedge clk_sys) disable iff (reset) output_update);
  edge_cov: cover property (@(posedge clk_sys) disable iff (reset) $rose(rising_edge_mode));
  short_cov: cover property (@(posedge clk_sys) disable iff (reset)
    sel_rise && bit_count != FULL_COUNT && port_powered);
endmodule // dac_serial_write_port

/* sim/dac_host.sv */
`timescale 1ns/10ps
module dac_host (
  output logic frame_select_n,
  output logic shift_clock,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic port_powered
);
  logic [15:0] rb;
  logic pp_mid;
  initial begin
    frame_select_n = 1'b1;
    shift_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // The shift clock idles low and stands still between frames.
  task automatic send(input logic [15:0] w, input int n, input bit rm);
    logic [15:0] s;
    s = w;
    frame_select_n = 1'b0;
    serial_data_in = s[15];
    #100;
    for (int i = 0; i < n; i++) begin
      shift_clock = 1'b1;
      if (!rm) begin
        serial_data_in = s[15];
        s = s << 1;
      end
      #100;
      rb = {rb[14:0], serial_data_out};
      pp_mid = port_powered;
      shift_clock = 1'b0;
      if (rm) begin
        s = s << 1;
        serial_data_in = s[15];
      end
      #100;
    end
    frame_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #200;
  endtask
endmodule // dac_host

/* sim/test_dac_serial_write_port.sv */
`timescale 1ns/10ps
module test_dac_serial_write_port;
  import dac_port_pkg::*;
  logic clk_sys, reset, serial_data_out, port_powered, rising_edge_mode;
  logic output_update, sink_ready, overflow, frame_select_n, shift_clock, serial_data_in;
  logic [DATA_BITS-1:0] current_output, exp_out;
  resolution_t resolution;
  logic [15:0] w, prev, kept;
  bit full_last, rmx;
  int error_cnt, checked, upd, ovf, cyc, exp_upd;
  int seed = 32'h5296_1576;
  dac_serial_write_port u_dut (.clk_sys(clk_sys), .reset(reset), .resolution(resolution),
    .frame_select_n(frame_select_n), .shift_clock(shift_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .port_powered(port_powered), .rising_edge_mode(rising_edge_mode),
    .current_output(current_output), .output_update(output_update),
    .sink_ready(sink_ready), .overflow(overflow));
  dac_host u_host (.frame_select_n(frame_select_n), .shift_clock(shift_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .port_powered(port_powered));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [DATA_BITS-1:0] expect_out(logic [15:0] wd, resolution_t r);
    logic [DATA_BITS-1:0] m;
    m = {DATA_BITS{1'b1}} << (2 * r);
    return wd[DATA_MSB:0] & m;
  endfunction
  task automatic frame(input logic [1:0] code, input int n, input bit rm);
    w = {code, 14'($random(seed))};
    u_host.send(w, n, rm);
    repeat (20) @(negedge clk_sys);
    if (n >= 16 && code == CODE_LOAD) begin
      exp_upd++;
      exp_out = expect_out(w, resolution);
    end
    if (n >= 16 && code == CODE_RISE) rmx = 1'b1;
    check(upd, exp_upd);
    check(current_output, exp_out);
    check(rising_edge_mode, rmx);
    check(u_host.pp_mid, 1'b1);
    check(port_powered, 1'b0);
    if (n == 16 && !rm && full_last) check(u_host.rb, prev);
    full_last = (n == 16);
    prev = w;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    cyc++;
    if (output_update === 1'b1) upd++;
    if (overflow === 1'b1) ovf++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    reset = 1'b1;
    sink_ready = 1'b1;
    resolution = RES_14;
    exp_out = ZERO_SCALE;
    prev = SHIFT_RESET;
    full_last = 1'b1;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(current_output, ZERO_SCALE);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_sys) resolution = resolution_t'(k % 4);
      frame(CODE_LOAD, 16, 0);
    end
    frame(2'h1, 16, 0);
    frame(2'h2, 16, 0);
    frame(CODE_LOAD, 15, 0);
    frame(CODE_RISE, 16, 0);
    frame(CODE_LOAD, 16, 1);
    @(negedge clk_sys) sink_ready = 1'b0;
    for (int k = 0; k < FIFO_DEPTH + 1; k++) begin
      w = {CODE_LOAD, 14'($random(seed))};
      if (k == FIFO_DEPTH - 1) kept = w;
      u_host.send(w, 16, 1);
    end
    repeat (20) @(negedge clk_sys);
    check(ovf, 1);
    check(upd, exp_upd);
    sink_ready = 1'b1;
    repeat (100) @(negedge clk_sys);
    check(upd, exp_upd + FIFO_DEPTH);
    check(current_output, expect_out(kept, resolution));
    exp_upd += FIFO_DEPTH;
    reset = 1'b1;
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(current_output, ZERO_SCALE);
    check(rising_edge_mode, 1'b0);
    exp_out = ZERO_SCALE;
    rmx = 1'b0;
    prev = SHIFT_RESET;
    full_last = 1'b1;
    frame(CODE_LOAD, 16, 0);
    give_verdict();
  end
endmodule // test_dac_serial_write_port
